// ### ncc_command_unit.sv
`timescale 1ns/1ps
// Summary of operation
// - Set-value command loads low byte plus high byte times 256.
// - Set-value and decimal mode commands clear the repeat tally.
// - Decimal command: five semicolon-ended ASCII fields, limits 65535 and 255.
// - Start below end with nonzero step and repeat counts up.
// - Start above end with nonzero step and repeat counts down.
// - Equal bounds, zero step or zero repeat holds the value.
// - Each advance that stays within range changes the value by the step size.
// - Each value is emitted repeat-count times before stepping.
// - Fifth decimal field loads the current counter value.
// - An empty decimal field keeps its previous setting.
// - Malformed decimal command is discarded; an offending non-digit byte and the bytes after it pass on.
// - Counting up past maximum wraps to minimum.
// - Counting down below minimum wraps to maximum.
// - Up mode: out-of-range value forced to minimum on print.
// - Down mode: out-of-range value forced to maximum on print.
// - Reset gives start 1, end 65535, step 1, repeat 1, value 1.
// - Print command emits current value, then advances the counter.
// - Digit format: width 0 to 5 and placement 0 to 2.
module ncc_command_unit
(
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    input  wire logic         rx_valid,
    input  wire logic [7:0]   rx_data,
    output logic              rx_ready,
    output logic              pass_valid,
    output logic [7:0]        pass_data,
    output ncc_pkg::ncc_print_t print_out,
    output logic [15:0]       counter_value,
    output ncc_pkg::ncc_mode_t mode_out,
    output logic              malformed
);

    typedef enum {
        ST_IDLE,
        ST_GROUP,
        ST_COUNTER,
        ST_ARG_A,
        ST_ARG_B,
        ST_FIELD
    } ncc_state_t;

    typedef enum {
        OP_VALUE,
        OP_BINARY,
        OP_FORMAT
    } ncc_op_t;

    typedef struct packed {
        ncc_state_t         state;
        ncc_op_t            op;
        logic [2:0]         arg_index;
        logic [7:0]         arg_low;
        logic [7:0]         arg_b2;
        logic [7:0]         arg_b3;
        logic [7:0]         arg_b4;
        logic [7:0]         arg_b5;
        logic [2:0]         field;
        logic [4:0]         seen;
        logic [4:0]         failed;
        ncc_pkg::ncc_mode_t mode;
        logic [15:0]        value;
        logic [7:0]         tally;
        ncc_pkg::ncc_format_t format;
        ncc_pkg::ncc_print_t  print;
        logic               pass_valid;
        logic [7:0]         pass_data;
        logic               malformed;
    } ncc_regs_t;

    ncc_regs_t r;
    ncc_regs_t next_r;

    logic              take;
    logic [4:0]        f_clear;
    logic [4:0]        f_take;
    logic [16:0]       f_value [5];
    logic [4:0]        f_present;
    logic [4:0]        f_bad;
    ncc_pkg::ncc_dir_t dir;
    logic [15:0]       start_value;
    logic [15:0]       step_value;
    logic [7:0]        step_tally;

    function automatic logic [15:0] join_bytes(input logic [7:0] lo,
                                               input logic [7:0] hi);
        join_bytes = 16'(lo) + 16'(hi) * ncc_pkg::BYTE_WEIGHT;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_field
            ncc_dec_field u_field
            (
                .ref_clk (ref_clk),
                .reset_n (reset_n),
                .clear   (f_clear[gi]),
                .take    (f_take[gi]),
                .data    (rx_data),
                .limit   ((gi == 2 || gi == 3) ? ncc_pkg::NARROW_LIMIT
                                               : ncc_pkg::WIDE_LIMIT),
                .value   (f_value[gi]),
                .present (f_present[gi]),
                .bad     (f_bad[gi])
            );
        end
    endgenerate

    ncc_stepper u_stepper
    (
        .mode        (r.mode),
        .value       (r.value),
        .tally       (r.tally),
        .dir         (dir),
        .start_value (start_value),
        .next_value  (step_value),
        .next_tally  (step_tally)
    );

    assign rx_ready = 1'b1;
    assign take = rx_valid;

    always_comb
    begin
        next_r = r;
        next_r.pass_valid = 1'b0;
        next_r.print.valid = 1'b0;
        next_r.malformed = 1'b0;
        f_clear = '0;
        f_take = '0;
        if (take)
        begin
            unique case (r.state)
                ST_IDLE:
                begin
                    if (rx_data == ncc_pkg::CMD_GROUP)
                    begin
                        next_r.state = ST_GROUP;
                    end
                    else
                    begin
                        next_r.pass_valid = 1'b1;
                        next_r.pass_data = rx_data;
                    end
                end
                ST_GROUP:
                begin
                    next_r.state = ST_IDLE;
                    if (rx_data == ncc_pkg::CMD_COUNTER)
                    begin
                        next_r.state = ST_COUNTER;
                    end
                    else if (rx_data == ncc_pkg::CMD_PRINT)
                    begin
                        next_r.print.valid = 1'b1;
                        next_r.print.value = start_value;
                        next_r.print.format = r.format;
                        next_r.value = step_value;
                        next_r.tally = step_tally;
                    end
                    else
                    begin
                        next_r.pass_valid = 1'b1;
                        next_r.pass_data = rx_data;
                    end
                end
                ST_COUNTER:
                begin
                    next_r.state = ST_ARG_A;
                    next_r.arg_index = 3'h0;
                    unique case (rx_data)
                        ncc_pkg::SUB_SET_VALUE: next_r.op = OP_VALUE;
                        ncc_pkg::SUB_BINARY:    next_r.op = OP_BINARY;
                        ncc_pkg::SUB_FORMAT:    next_r.op = OP_FORMAT;
                        ncc_pkg::SUB_DECIMAL:
                        begin
                            next_r.state = ST_FIELD;
                            next_r.field = 3'h0;
                            f_clear = '1;
                        end
                        default: next_r.state = ST_IDLE;
                    endcase
                end
                ST_ARG_A:
                begin
                    next_r.arg_index = r.arg_index + 3'h1;
                    unique case (r.arg_index)
                        3'h0: next_r.arg_low = rx_data;
                        3'h1: next_r.arg_b2 = rx_data;
                        3'h2: next_r.arg_b3 = rx_data;
                        3'h3: next_r.arg_b4 = rx_data;
                        3'h4: next_r.arg_b5 = rx_data;
                        default: next_r.arg_low = r.arg_low;
                    endcase
                    if (r.op == OP_VALUE && r.arg_index == 3'h1)
                    begin
                        next_r.state = ST_IDLE;
                        next_r.value = join_bytes(r.arg_low, rx_data);
                        next_r.tally = 8'h00;
                    end
                    else if (r.op == OP_FORMAT && r.arg_index == 3'h1)
                    begin
                        next_r.state = ST_IDLE;
                        if (r.arg_low <= 8'(ncc_pkg::MAX_WIDTH)
                            && rx_data <= 8'(ncc_pkg::MAX_PLACE))
                        begin
                            next_r.format.digit_width = r.arg_low[2:0];
                            next_r.format.digit_place = rx_data[1:0];
                        end
                    end
                    else if (r.op == OP_BINARY && r.arg_index == 3'h5)
                    begin
                        next_r.state = ST_IDLE;
                        next_r.mode.range_start = join_bytes(r.arg_low,
                                                             r.arg_b2);
                        next_r.mode.range_end = join_bytes(r.arg_b3,
                                                           r.arg_b4);
                        next_r.mode.step_size = r.arg_b5;
                        next_r.mode.repeat_count = rx_data;
                        next_r.tally = 8'h00;
                    end
                end
                ST_FIELD:
                begin
                    if (rx_data == ncc_pkg::SEMICOLON)
                    begin
                        next_r.field = r.field + 3'h1;
                        if (r.field == ncc_pkg::FIELD_COUNT - 3'h1)
                        begin
                            next_r.state = ST_IDLE;
                            if (f_bad == '0)
                            begin
                                for (int i = 0; i < 5; i++)
                                begin
                                    if (!f_present[i])
                                    begin
                                        continue;
                                    end
                                    unique case (i)
                                        0: next_r.mode.range_start =
                                               f_value[0][15:0];
                                        1: next_r.mode.range_end =
                                               f_value[1][15:0];
                                        2: next_r.mode.step_size =
                                               f_value[2][7:0];
                                        3: next_r.mode.repeat_count =
                                               f_value[3][7:0];
                                        default: next_r.value =
                                               f_value[4][15:0];
                                    endcase
                                end
                                next_r.tally = 8'h00;
                            end
                            else
                            begin
                                next_r.malformed = 1'b1;
                            end
                        end
                    end
                    else
                    begin
                        f_take[r.field] = 1'b1;
                        if (rx_data < ncc_pkg::DIGIT_ZERO
                            || rx_data > ncc_pkg::DIGIT_NINE)
                        begin
                            next_r.state = ST_IDLE;
                            next_r.malformed = 1'b1;
                            next_r.pass_valid = 1'b1;
                            next_r.pass_data = rx_data;
                        end
                    end
                end
                default: next_r.state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            r <= '0;
            r.state <= ST_IDLE;
            r.op <= OP_VALUE;
            r.mode.range_start <= ncc_pkg::RESET_RANGE_START;
            r.mode.range_end <= ncc_pkg::RESET_RANGE_END;
            r.mode.step_size <= ncc_pkg::RESET_STEP;
            r.mode.repeat_count <= ncc_pkg::RESET_REPEAT;
            r.value <= ncc_pkg::RESET_PRESET;
            r.format.digit_width <= ncc_pkg::RESET_WIDTH;
            r.format.digit_place <= ncc_pkg::RESET_PLACE;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign pass_valid = r.pass_valid;
    assign pass_data = r.pass_data;
    assign print_out = r.print;
    assign counter_value = r.value;
    assign mode_out = r.mode;
    assign malformed = r.malformed;

endmodule // ncc_command_unit

// ### ncc_pkg.sv
package ncc_pkg;

    localparam logic [7:0] CMD_GROUP     = 8'h1d;
    localparam logic [7:0] CMD_COUNTER   = 8'h43;
    localparam logic [7:0] CMD_PRINT     = 8'h63;
    localparam logic [7:0] SUB_SET_VALUE = 8'h32;
    localparam logic [7:0] SUB_BINARY    = 8'h31;
    localparam logic [7:0] SUB_FORMAT    = 8'h30;
    localparam logic [7:0] SUB_DECIMAL   = 8'h3b;
    localparam logic [7:0] SEMICOLON     = 8'h3b;
    localparam logic [7:0] DIGIT_ZERO    = 8'h30;
    localparam logic [7:0] DIGIT_NINE    = 8'h39;

    localparam logic [15:0] RESET_RANGE_START = 16'h0001;
    localparam logic [15:0] RESET_RANGE_END   = 16'hffff;
    localparam logic [7:0]  RESET_STEP        = 8'h01;
    localparam logic [7:0]  RESET_REPEAT      = 8'h01;
    localparam logic [15:0] RESET_PRESET      = 16'h0001;
    localparam logic [2:0]  RESET_WIDTH       = 3'h0;
    localparam logic [1:0]  RESET_PLACE       = 2'h0;
    localparam logic [2:0]  MAX_WIDTH         = 3'h5;
    localparam logic [1:0]  MAX_PLACE         = 2'h2;
    localparam logic [2:0]  FIELD_COUNT       = 3'h5;
    localparam logic [15:0] BYTE_WEIGHT       = 16'h0100;
    localparam logic [16:0] WIDE_LIMIT        = 17'h0ffff;
    localparam logic [16:0] NARROW_LIMIT      = 17'h000ff;

    typedef struct packed {
        logic [15:0] range_start;
        logic [15:0] range_end;
        logic [7:0]  step_size;
        logic [7:0]  repeat_count;
    } ncc_mode_t;

    typedef struct packed {
        logic [2:0] digit_width;
        logic [1:0] digit_place;
    } ncc_format_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] value;
        ncc_format_t format;
    } ncc_print_t;

    typedef enum logic [1:0] {
        NCC_HOLD,
        NCC_UP,
        NCC_DOWN
    } ncc_dir_t;

endpackage

// ### ncc_dec_field.sv
`timescale 1ns/1ps
// Accumulates one decimal ASCII field; flags non-digits and overflow.
module ncc_dec_field
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        clear,
    input  wire logic        take,
    input  wire logic [7:0]  data,
    input  wire logic [16:0] limit,
    output logic [16:0]      value,
    output logic             present,
    output logic             bad
);

    typedef struct packed {
        logic [16:0] value;
        logic        present;
        logic        bad;
    } ncc_acc_t;

    ncc_acc_t acc;
    ncc_acc_t next_acc;
    logic     is_digit;
    logic [20:0] wide;

    always_comb
    begin
        next_acc = acc;
        is_digit = (data >= ncc_pkg::DIGIT_ZERO)
                && (data <= ncc_pkg::DIGIT_NINE);
        wide = 21'(acc.value) * 21'd10 + 21'(data - ncc_pkg::DIGIT_ZERO);
        if (clear)
        begin
            next_acc = '0;
        end
        else if (take)
        begin
            if (!is_digit)
            begin
                next_acc.bad = 1'b1;
            end
            else if (wide > 21'(limit))
            begin
                next_acc.bad = 1'b1;
            end
            else
            begin
                next_acc.value = wide[16:0];
                next_acc.present = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            acc <= '0;
        end
        else
        begin
            acc <= next_acc;
        end
    end

    assign value = acc.value;
    assign present = acc.present;
    assign bad = acc.bad;

endmodule // ncc_dec_field

// ### ncc_stepper.sv
`timescale 1ns/1ps
// Combinational next counter value for one print-counter command.
module ncc_stepper
(
    input  wire ncc_pkg::ncc_mode_t mode,
    input  wire logic [15:0]        value,
    input  wire logic [7:0]         tally,
    output ncc_pkg::ncc_dir_t       dir,
    output logic [15:0]             start_value,
    output logic [15:0]             next_value,
    output logic [7:0]              next_tally
);

    logic [15:0] lo;
    logic [15:0] hi;
    logic [16:0] up_sum;
    logic [16:0] down_gap;

    always_comb
    begin
        dir = ncc_pkg::NCC_HOLD;
        if (mode.step_size != 8'h00 && mode.repeat_count != 8'h00)
        begin
            if (mode.range_start < mode.range_end)
            begin
                dir = ncc_pkg::NCC_UP;
            end
            else if (mode.range_start > mode.range_end)
            begin
                dir = ncc_pkg::NCC_DOWN;
            end
        end
        lo = (dir == ncc_pkg::NCC_DOWN) ? mode.range_end : mode.range_start;
        hi = (dir == ncc_pkg::NCC_DOWN) ? mode.range_start : mode.range_end;
        start_value = value;
        if (dir == ncc_pkg::NCC_UP && (value < lo || value > hi))
        begin
            start_value = lo;
        end
        if (dir == ncc_pkg::NCC_DOWN && (value < lo || value > hi))
        begin
            start_value = hi;
        end
        up_sum = 17'(start_value) + 17'(mode.step_size);
        down_gap = 17'(start_value) - 17'(lo);
        next_value = start_value;
        next_tally = tally;
        if (dir != ncc_pkg::NCC_HOLD)
        begin
            if (8'(tally + 8'h01) >= mode.repeat_count)
            begin
                next_tally = 8'h00;
                if (dir == ncc_pkg::NCC_UP)
                begin
                    next_value = (up_sum > 17'(hi)) ? lo : up_sum[15:0];
                end
                else
                begin
                    next_value = (down_gap < 17'(mode.step_size)) ? hi
                        : 16'(start_value - 16'(mode.step_size));
                end
            end
            else
            begin
                next_tally = 8'(tally + 8'h01);
            end
        end
    end

endmodule // ncc_stepper

// ### ncc_command_unit_checker.sv
`timescale 1ns/1ps
module ncc_command_unit_checker
(
    input wire logic               ref_clk,
    input wire logic               reset_n,
    input wire logic               rx_valid,
    input wire logic [7:0]         rx_data,
    input wire logic               rx_ready,
    input wire logic               pass_valid,
    input wire logic [7:0]         pass_data,
    input wire ncc_pkg::ncc_print_t print_out,
    input wire logic [15:0]        counter_value,
    input wire ncc_pkg::ncc_mode_t mode_out,
    input wire logic               malformed
);
    logic [15:0] s;
    logic [15:0] e;
    logic [15:0] pv;
    logic [7:0]  st;
    logic [16:0] usum;
    logic [16:0] dlim;
    logic        go;
    logic        up;
    logic        dn;
    logic        pr;
    assign s    = mode_out.range_start;
    assign e    = mode_out.range_end;
    assign st   = mode_out.step_size;
    assign pv   = print_out.value;
    assign usum = {1'b0, pv} + {9'h000, st};
    assign dlim = {1'b0, e} + {9'h000, st};
    assign go   = st != 8'h00 && mode_out.repeat_count != 8'h00;
    assign up   = go && s < e;
    assign dn   = go && s > e;
    assign pr   = print_out.valid && mode_out.repeat_count == 8'h01;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    chk_reset_vals: assert property (
        $rose(reset_n) |-> counter_value == 16'h0001 &&
        mode_out == {16'h0001, 16'hffff, 8'h01, 8'h01})
        else $error("Reset values wrong.");
    chk_hold_value: assert property (
        print_out.valid && !up && !dn |-> counter_value == pv)
        else $error("Held counter moved.");
    chk_step_up: assert property (
        pr && up && usum <= {1'b0, e} |-> counter_value == usum[15:0])
        else $error("Up step wrong.");
    chk_wrap_up: assert property (
        pr && up && usum > {1'b0, e} |-> counter_value == s)
        else $error("Up wrap wrong.");
    chk_step_down: assert property (
        pr && dn && {1'b0, pv} >= dlim |-> counter_value == pv - st)
        else $error("Down step wrong.");
    chk_wrap_down: assert property (
        pr && dn && {1'b0, pv} < dlim |-> counter_value == s)
        else $error("Down wrap wrong.");
    chk_force_up: assert property (
        print_out.valid && up |-> pv >= s && pv <= e)
        else $error("Up print out of range.");
    chk_force_down: assert property (
        print_out.valid && dn |-> pv <= s && pv >= e)
        else $error("Down print out of range.");
    chk_print_pulse: assert property (
        print_out.valid |=> !print_out.valid)
        else $error("Print pulse too long.");
    chk_quiet_hold: assert property (
        !$past(rx_valid) |-> $stable(counter_value) && $stable(mode_out))
        else $error("State moved without input.");
    chk_bad_pulse: assert property (
        malformed |=> !malformed)
        else $error("Malformed pulse too long.");
endmodule // ncc_command_unit_checker

bind ncc_command_unit ncc_command_unit_checker ncc_command_unit_checker_inst
(
    .ref_clk(ref_clk), .reset_n(reset_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .pass_valid(pass_valid),
    .pass_data(pass_data), .print_out(print_out),
    .counter_value(counter_value), .mode_out(mode_out),
    .malformed(malformed)
);

// ### ncc_host.sv
`timescale 1ns/1ps
// Host that streams queued command bytes, one per cycle or every other.
module ncc_host
(
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic slow,
    output logic      rx_valid,
    output logic [7:0] rx_data
);
    logic [7:0] q[$];
    logic       gap;
    initial
    begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        gap      = 1'b0;
    end
    always @(posedge ref_clk)
    begin
        gap <= ~gap;
        if (reset_n && q.size() != 0 && !(slow && gap))
        begin
            rx_valid <= 1'b1;
            rx_data  <= q.pop_front();
        end
        else
        begin
            rx_valid <= 1'b0;
            // The idle line must not keep showing the last byte.
            rx_data  <= ~rx_data;
        end
    end
endmodule // ncc_host

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
    logic                ref_clk;
    logic                reset_n;
    logic                slow;
    logic                rx_valid;
    logic [7:0]          rx_data;
    logic                rx_ready;
    logic                pass_valid;
    logic [7:0]          pass_data;
    ncc_pkg::ncc_print_t print_out;
    logic [15:0]         counter_value;
    ncc_pkg::ncc_mode_t  mode_out;
    logic                malformed;
    integer              seed;
    integer              n_mismatch;
    integer              num_checks;
    integer              n_mal;
    integer              i;
    integer              k;
    logic [20:0]         pq[$];
    logic [20:0]         eq[$];
    logic [7:0]          fwd[$];
    logic [15:0]         ms;
    logic [15:0]         me;
    logic [15:0]         mc;
    logic [7:0]          mst;
    logic [7:0]          mrp;
    logic [7:0]          mt;
    logic [4:0]          mf;

    ncc_command_unit ncc_command_unit_inst (.ref_clk(ref_clk),
        .reset_n(reset_n), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .pass_valid(pass_valid),
        .pass_data(pass_data), .print_out(print_out),
        .counter_value(counter_value), .mode_out(mode_out),
        .malformed(malformed));
    ncc_host ncc_host_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data));

    always #25 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        if (print_out.valid === 1'b1)
            pq.push_back({print_out.value, print_out.format});
        if (pass_valid === 1'b1)
            fwd.push_back(pass_data);
        if (malformed === 1'b1)
            n_mal++;
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic send(input logic [7:0] b);
        ncc_host_inst.q.push_back(b);
    endtask
    task automatic send_str(input string s);
        for (int j = 0; j < s.len(); j++)
            send(s[j]);
    endtask
    task automatic cmd(input logic [7:0] sub);
        send(8'h1d);
        send(8'h43);
        send(sub);
    endtask
    task automatic dec(input int s, e, st, rp, pv);
        cmd(8'h3b);
        send_str($sformatf("%0d;%0d;%0d;%0d;%0d;", s, e, st, rp, pv));
        {ms, me, mst, mrp, mc, mt} = {s[15:0], e[15:0], st[7:0],
                                      rp[7:0], pv[15:0], 8'h00};
    endtask
    task automatic setv(input logic [15:0] v);
        cmd(8'h32);
        send(v[7:0]);
        send(v[15:8]);
        {mc, mt} = {v, 8'h00};
    endtask
    task automatic binm(input logic [15:0] s, e, input logic [7:0] st, rp);
        logic [47:0] w;
        w = {rp, st, e, s};
        cmd(8'h31);
        for (int j = 0; j < 6; j++)
            send(w[8*j +: 8]);
        {ms, me, mst, mrp, mt} = {s, e, st, rp, 8'h00};
    endtask
    task automatic fmt(input logic [7:0] m, n);
        cmd(8'h30);
        send(m);
        send(n);
        if (m <= 8'h05 && n <= 8'h02)
            mf = {m[2:0], n[1:0]};
    endtask
    task automatic mprint();
        logic up;
        logic dn;
        up = ms < me && mst != 8'h00 && mrp != 8'h00;
        dn = ms > me && mst != 8'h00 && mrp != 8'h00;
        if ((up && (mc < ms || mc > me)) || (dn && (mc > ms || mc < me)))
            mc = ms;
        eq.push_back({mc, mf});
        send(8'h1d);
        send(8'h63);
        mt = mt + 8'h01;
        if ((up || dn) && mt >= mrp)
        begin
            mt = 8'h00;
            if (up)
                mc = ({1'b0, mc} + mst > me) ? ms : mc + mst;
            else
                mc = ({1'b0, mc} < {1'b0, me} + mst) ? ms : mc - mst;
        end
    endtask
    task automatic verify();
        for (k = 0; k < 5000 && (ncc_host_inst.q.size() != 0 ||
             rx_valid === 1'b1); k++)
            @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
        chk({k < 5000, rx_ready}, 2'b11);
        chk(mode_out, {ms, me, mst, mrp});
        chk(counter_value, mc);
        while (eq.size() != 0)
            chk(pq.size() != 0 ? pq.pop_front() : 21'h0, eq.pop_front());
        chk(pq.size(), 0);
    endtask

    initial
    begin
        {ref_clk, reset_n, slow, seed, n_mismatch, num_checks} = 0;
        {n_mal, mt, mf} = 0;
        seed = 79798;
        {ms, me, mst, mrp, mc} = {16'h1, 16'hffff, 8'h1, 8'h1, 16'h1};
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk(mode_out, {16'h1, 16'hffff, 8'h1, 8'h1});
        chk(counter_value, 16'h1);
        mprint();
        setv(16'h0000);
        mprint();
        verify();
        dec(50, 0, 5, 2, 50);
        repeat (6) mprint();
        setv(16'd40);
        repeat (3) mprint();
        verify();
        dec(65530, 65535, 4, 1, 65535);
        repeat (3) mprint();
        verify();
        dec(7, 7, 1, 1, 9);
        repeat (2) mprint();
        verify();
        cmd(8'h3b);
        send_str("20;;;;;");
        {ms, mt} = {16'd20, 8'h00};
        verify();
        cmd(8'h3b);
        send_str("12xA");
        send(8'h1d);
        send_str("B");
        verify();
        chk({24'(fwd.size()), fwd[0], fwd[1], fwd[2]}, {24'd3, "xAB"});
        cmd(8'h3b);
        send_str("70000;;;;;");
        cmd(8'h3b);
        send_str(";;256;;;");
        verify();
        chk(n_mal, 3);
        for (i = 0; i < 8; i++)
        begin
            fmt(i[7:0], i[7:0] % 4);
            mprint();
        end
        verify();
        for (i = 0; i < 24; i++)
        begin
            slow <= $random(seed);
            case ($random(seed) & 3)
                0: dec($random(seed) & 31, $random(seed) & 31,
                       $random(seed) & 7, $random(seed) & 3,
                       $random(seed) & 63);
                1: binm($random(seed) & 31, $random(seed) & 31,
                        $random(seed) & 7, $random(seed) & 3);
                2: setv($random(seed) & 63);
                default: fmt($random(seed) & 7, $random(seed) & 3);
            endcase
            repeat (($random(seed) & 7) + 1) mprint();
            verify();
        end
        finish_test;
    end

    initial
    begin
        repeat (40000) @(posedge ref_clk);
        n_mismatch++;
        finish_test;
    end
endmodule // testbench
